/* File: icad_config_decode.sv */
`timescale 1ns/1ps

module icad_config_decode (
  // Host bus clock and synchronous active-low reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration mode level from the entry sequence logic
  input wire logic cfg_mode,
  // One-cycle strobe: load config index from host_wdata
  input wire logic index_wr,
  // One-cycle strobe: write data to the indexed register
  input wire logic data_wr,
  // One-cycle strobe: read the indexed register
  input wire logic data_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic [7:0] config_index_reg,
  // Host I/O address bus and chip select
  input wire logic [10:0] addr,
  input wire logic chip_select_n,
  // Control bit held elsewhere: pin acts as power good
  input wire logic power_good,
  // Parallel port mode inputs
  input wire logic epp_enable,
  input wire logic ecp_mode,
  // Floppy drive selection and the controller's density signals
  input wire logic [1:0] drive_sel,
  input wire logic density_select,
  input wire logic rate_bit_0,
  input wire logic rate_bit_1,
  output logic density_out_0,
  output logic density_out_1,
  // Decoded chip selects
  output icad_pkg::icad_sel_t sel
);

  // Whole state of the block
  typedef struct packed {
    logic [7:0] index;
    icad_pkg::icad_regs_t regs;
    logic [7:0] rdata;
    icad_pkg::icad_sel_t sel;
    logic den0;
    logic den1;
  } icad_state_t;

  // Value every flip-flop takes under reset
  localparam icad_state_t STATE_RST = '{
    index: icad_pkg::RST_INDEX,
    regs: '{
      test_bits_low: icad_pkg::RST_TEST,
      test_bits_mid: icad_pkg::RST_TEST,
      test_bits_high: icad_pkg::RST_TEST,
      game_select_base: icad_pkg::RST_GAME_BASE,
      drive_type_select: icad_pkg::RST_DRIVE_TYPE,
      floppy_base: icad_pkg::RST_FLOPPY_BASE,
      disk_ctrl_block_base: icad_pkg::RST_DISK_CTRL,
      disk_alt_status_base: icad_pkg::RST_DISK_ALT,
      printer_port_base: icad_pkg::RST_PRINTER
    },
    rdata: 8'h00,
    sel: '0,
    den0: 1'b0,
    den1: 1'b0
  };

  // Current and next state
  icad_state_t st;
  icad_state_t next_st;

  // Masked write: only bits set in mask take new data
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Upper qualification: chip select low and A10 low
  function automatic logic upper_ok(input logic cs_n,
                                    input logic a10);
    upper_ok = !cs_n && !a10;
  endfunction

  // Base field in bits 7:2 against A9:A4
  function automatic logic base6_hit(input logic [7:0] base,
                                     input logic [10:0] a);
    base6_hit = (base[7:2] == a[9:4]);
  endfunction

  // Top address bits at zero switch a decoder off
  function automatic logic base_on(input logic [7:0] base);
    base_on = (base[7:6] != 2'h0);
  endfunction

  // Read data for a given index
  function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                          input icad_pkg::icad_regs_t r);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      icad_pkg::IDX_TEST_LOW: begin
        v = r.test_bits_low;
      end
      icad_pkg::IDX_TEST_MID: begin
        v = r.test_bits_mid;
      end
      icad_pkg::IDX_TEST_HIGH: begin
        // Upper six bits are never stored
        v = r.test_bits_high & icad_pkg::WMASK_TEST_HIGH;
      end
      icad_pkg::IDX_GAME_BASE: begin
        v = r.game_select_base;
      end
      icad_pkg::IDX_DRIVE_TYPE: begin
        v = r.drive_type_select;
      end
      icad_pkg::IDX_FLOPPY_BASE: begin
        v = r.floppy_base;
      end
      icad_pkg::IDX_DISK_CTRL: begin
        v = r.disk_ctrl_block_base;
      end
      icad_pkg::IDX_DISK_ALT: begin
        v = r.disk_alt_status_base;
      end
      icad_pkg::IDX_PRINTER: begin
        v = r.printer_port_base;
      end
      default: begin
        // Reserved 12h-1Dh and unmapped indices read zero
        v = 8'h00;
      end
    endcase
    read_mux = v;
  endfunction

  // Register writes, reads and all decoding
  always_comb begin
    logic [1:0] dtype;
    logic [7:0] pb;
    logic game_hit;
    logic game_nib;
    logic prn_hit;
    logic prn_upper;
    dtype = 2'h0;
    pb = 8'h00;
    game_hit = 1'b0;
    game_nib = 1'b0;
    prn_hit = 1'b0;
    prn_upper = 1'b0;
    next_st = st;

    // Index and data strobes may share a cycle; the write then
    // lands at the index that was loaded before
    // Index is loaded only while configuration mode is on
    if (cfg_mode && index_wr) begin
      next_st.index = host_wdata;
    end

    // Data writes go to the register named by the index
    if (cfg_mode && data_wr) begin
      case (st.index)
        icad_pkg::IDX_TEST_LOW: begin
          // Stored as written; software keeps these at zero
          next_st.regs.test_bits_low = host_wdata;
        end
        icad_pkg::IDX_TEST_MID: begin
          next_st.regs.test_bits_mid = host_wdata;
        end
        icad_pkg::IDX_TEST_HIGH: begin
          // Only bits 1:0 are writable
          next_st.regs.test_bits_high = merge(
            st.regs.test_bits_high, host_wdata,
            icad_pkg::WMASK_TEST_HIGH);
        end
        icad_pkg::IDX_GAME_BASE: begin
          next_st.regs.game_select_base = host_wdata;
        end
        icad_pkg::IDX_DRIVE_TYPE: begin
          next_st.regs.drive_type_select = host_wdata;
        end
        icad_pkg::IDX_FLOPPY_BASE: begin
          // Low two bits stay at their fixed value
          next_st.regs.floppy_base = merge(
            st.regs.floppy_base, host_wdata,
            icad_pkg::WMASK_BASE6);
        end
        icad_pkg::IDX_DISK_CTRL: begin
          next_st.regs.disk_ctrl_block_base = merge(
            st.regs.disk_ctrl_block_base, host_wdata,
            icad_pkg::WMASK_BASE6);
        end
        icad_pkg::IDX_DISK_ALT: begin
          // Low bits stay 01; the decode ignores them and fixes nibble 6
          next_st.regs.disk_alt_status_base = merge(
            st.regs.disk_alt_status_base, host_wdata,
            icad_pkg::WMASK_BASE6);
        end
        icad_pkg::IDX_PRINTER: begin
          next_st.regs.printer_port_base = host_wdata;
        end
        default: begin
          // Reserved and unmapped indices ignore writes
          next_st.regs = st.regs;
        end
      endcase
    end

    // Reads have no side effect on any stored byte
    // Read data is captured on the strobe and then held
    if (data_rd) begin
      if (cfg_mode) begin
        next_st.rdata = read_mux(st.index, st.regs);
      end else begin
        // Outside configuration mode the registers are hidden
        next_st.rdata = 8'h00;
      end
    end

    // Game select: base match on A9:A4 plus mode nibble test
    game_hit = base6_hit(st.regs.game_select_base, addr);
    case (st.regs.game_select_base[icad_pkg::GAME_MODE_LSB +: 2])
      icad_pkg::GAME_OFF: begin
        game_nib = 1'b0;
      end
      icad_pkg::GAME_ONE_BYTE: begin
        game_nib = (addr[3:0] == icad_pkg::NIB_GAME_ONE);
      end
      icad_pkg::GAME_EIGHT: begin
        game_nib = !addr[3];
      end
      icad_pkg::GAME_SIXTEEN: begin
        game_nib = 1'b1;
      end
      default: begin
        game_nib = 1'b0;
      end
    endcase
    // Power-good use of the pin forces the game select off
    next_st.sel.game_port_select = game_hit && game_nib
      && upper_ok(chip_select_n, addr[10])
      && !power_good;

    // Floppy controller: eight registers in the low half
    next_st.sel.floppy_controller_sel =
      base_on(st.regs.floppy_base)
      && base6_hit(st.regs.floppy_base, addr)
      && upper_ok(chip_select_n, addr[10])
      && !addr[3];

    // Disk control block: eight registers in the low half
    next_st.sel.disk_ctrl_sel =
      base_on(st.regs.disk_ctrl_block_base)
      && base6_hit(st.regs.disk_ctrl_block_base, addr)
      && upper_ok(chip_select_n, addr[10])
      && !addr[3];

    // Alternate status: single byte at nibble 6
    next_st.sel.disk_alt_sel =
      base_on(st.regs.disk_alt_status_base)
      && base6_hit(st.regs.disk_alt_status_base, addr)
      && upper_ok(chip_select_n, addr[10])
      && (addr[3:0] == icad_pkg::NIB_ALT_STATUS);

    // Without EPP the base covers A9:A2; with it A9:A3
    // Printer port: 4-byte blocks, or 8-byte with EPP
    pb = st.regs.printer_port_base;
    if (epp_enable) begin
      prn_hit = (pb[7:1] == addr[9:3]);
    end else begin
      prn_hit = (pb == addr[9:2]);
    end
    // In ECP mode A10 picks the register bank instead
    if (ecp_mode) begin
      prn_upper = !chip_select_n;
    end else begin
      prn_upper = upper_ok(chip_select_n, addr[10]);
    end
    next_st.sel.printer_sel = base_on(pb) && prn_hit
      && prn_upper;

    // Field for drive n sits in bits 2n+1:2n, upper bit first
    // Density pins follow the type of the selected drive
    dtype = st.regs.drive_type_select[{drive_sel, 1'b0} +: 2];
    case (dtype)
      icad_pkg::DT_DENSITY_SELECT: begin
        next_st.den0 = density_select;
        next_st.den1 = rate_bit_0;
      end
      icad_pkg::DT_RATES_10: begin
        next_st.den0 = rate_bit_1;
        next_st.den1 = rate_bit_0;
      end
      icad_pkg::DT_DENSITY_SELECT_INV: begin
        next_st.den0 = !density_select;
        next_st.den1 = rate_bit_0;
      end
      icad_pkg::DT_RATES_01: begin
        next_st.den0 = rate_bit_0;
        next_st.den1 = rate_bit_1;
      end
      default: begin
        next_st.den0 = density_select;
        next_st.den1 = rate_bit_0;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a plain flip-flop, so each decode lags the
  // address it answers by one clock
  // Outputs straight from the state flip-flops
  assign host_rdata = st.rdata;
  assign config_index_reg = st.index;
  assign sel = st.sel;
  assign density_out_0 = st.den0;
  assign density_out_1 = st.den1;

endmodule

/* File: icad_config_decode_bench.sv */
`timescale 1ns/1ps
// Bench: register access through the host model, random decode sweep
module icad_config_decode_bench;
  typedef struct {string what; logic [7:0] v;} icad_note_t;
  logic ref_clk = 1'b0, nrst = 1'b0, cfg_mode = 1'b0, chip_select_n = 1'b1;
  logic power_good = 1'b0, epp_enable = 1'b0, ecp_mode = 1'b0;
  logic density_select = 1'b0, rate_bit_0 = 1'b0, rate_bit_1 = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [1:0] drive_sel = 2'h0;
  logic index_wr, data_wr, data_rd, rd_done, probe = 1'b0;
  logic density_out_0, density_out_1;
  logic [7:0] host_wdata, host_rdata, config_index_reg, rd_byte;
  logic [7:0] cur_idx = 8'h00;
  icad_pkg::icad_sel_t sel;
  icad_note_t q[$], n;
  int n_fail = 0, checks_done = 0;
  // Indices, reset values and writable masks of the register slice
  logic [7:0] ix[9] = '{icad_pkg::IDX_TEST_LOW, icad_pkg::IDX_TEST_MID,
    icad_pkg::IDX_TEST_HIGH, icad_pkg::IDX_GAME_BASE,
    icad_pkg::IDX_DRIVE_TYPE, icad_pkg::IDX_FLOPPY_BASE,
    icad_pkg::IDX_DISK_CTRL, icad_pkg::IDX_DISK_ALT, icad_pkg::IDX_PRINTER};
  logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h3c, 8'h3c,
    8'h3d, 8'h00};
  logic [7:0] wm[9] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hfc, 8'hfc,
    8'hfc, 8'hff};
  logic [7:0] rm[9];
  // Clock of 20 ns period
  always #10 ref_clk = ~ref_clk;
  icad_host_model icad_host_model_i (.ref_clk(ref_clk),
    .host_rdata(host_rdata), .index_wr(index_wr), .data_wr(data_wr),
    .data_rd(data_rd), .host_wdata(host_wdata), .rd_done(rd_done),
    .rd_byte(rd_byte));
  icad_config_decode icad_config_decode_i (.ref_clk(ref_clk), .nrst(nrst),
    .cfg_mode(cfg_mode), .index_wr(index_wr), .data_wr(data_wr),
    .data_rd(data_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .config_index_reg(config_index_reg), .addr(addr),
    .chip_select_n(chip_select_n), .power_good(power_good),
    .epp_enable(epp_enable), .ecp_mode(ecp_mode), .drive_sel(drive_sel),
    .density_select(density_select), .rate_bit_0(rate_bit_0),
    .rate_bit_1(rate_bit_1), .density_out_0(density_out_0),
    .density_out_1(density_out_1), .sel(sel));
  // Expected density pins and selects from the bench's register copy
  function automatic logic [7:0] exp_dec();
    logic q0, m, g, f, c, s, p;
    logic [1:0] t, d;
    q0 = !chip_select_n && !addr[10];
    t = rm[4][2*drive_sel +: 2];
    case (t)
      2'h0: d = {density_select, rate_bit_0};
      2'h1: d = {rate_bit_1, rate_bit_0};
      2'h2: d = {!density_select, rate_bit_0};
      default: d = {rate_bit_0, rate_bit_1};
    endcase
    case (rm[3][1:0])
      2'h0: m = 1'b0;
      2'h1: m = addr[3:0] == 4'h1;
      2'h2: m = !addr[3];
      default: m = 1'b1;
    endcase
    g = m && q0 && !power_good && addr[9:4] == rm[3][7:2];
    f = q0 && rm[5][7:6] != 2'h0 && addr[9:4] == rm[5][7:2] && !addr[3];
    c = q0 && rm[6][7:6] != 2'h0 && addr[9:4] == rm[6][7:2] && !addr[3];
    s = q0 && rm[7][7:6] != 2'h0 && addr[9:4] == rm[7][7:2]
        && addr[3:0] == 4'h6;
    p = !chip_select_n && (ecp_mode || !addr[10]) && rm[8][7:6] != 2'h0
        && (epp_enable ? addr[9:3] == rm[8][7:1] : addr[9:2] == rm[8]);
    return {1'b0, d, g, f, c, s, p};
  endfunction
  // Note an expected read, then run the read cycle
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    // Index loads only in configuration mode
    if (cfg_mode) begin
      cur_idx = i;
    end
    q.push_back('{"config index", cur_idx});
    q.push_back('{"register read", e});
    icad_host_model_i.access(1'b0, i, 8'h00);
  endtask
  // Write a register entry and track it in the copy
  task automatic wr(input int k, input logic [7:0] v);
    cur_idx = ix[k];
    icad_host_model_i.access(1'b1, ix[k], v);
    rm[k] = (v & wm[k]) | (rv[k] & ~wm[k]);
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Oldest note against one observed value
  task automatic cmp(input logic [7:0] seen);
    n = q.pop_front();
    checks_done++;
    if (seen !== n.v) begin
      $display("ERROR %s expected %h seen %h", n.what, n.v, seen);
      n_fail++;
    end
  endtask
  // Result watcher: index and read data, or sampled outputs
  always @(posedge ref_clk) begin
    if (rd_done) begin
      cmp(config_index_reg);
      cmp(rd_byte);
    end else if (probe) begin
      cmp({1'b0, density_out_0, density_out_1, sel});
    end
  end
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  // Main sequence
  initial begin
    rm = rv;
    void'($urandom(61));
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    cfg_mode = 1'b1;
    for (int k = 0; k < 9; k++) rd(ix[k], rv[k]);
    rd(8'h15, 8'h00);
    cfg_mode = 1'b0;
    icad_host_model_i.access(1'b1, icad_pkg::IDX_GAME_BASE, 8'h00);
    rd(icad_pkg::IDX_GAME_BASE, 8'h00);
    cfg_mode = 1'b1;
    rd(icad_pkg::IDX_GAME_BASE, 8'h80);
    icad_host_model_i.access(1'b1, 8'h15, 8'hff);
    rd(8'h15, 8'h00);
    for (int k = 0; k < 9; k++) begin
      wr(k, 8'hff);
      rd(ix[k], rm[k]);
    end
    for (int it = 0; it < 240; it++) begin
      if (it % 24 == 0) begin
        // Software keeps test bits at zero
        for (int k = 0; k < 9; k++) wr(k, k < 3 ? 8'h00 : 8'($urandom));
      end
      @(negedge ref_clk);
      addr = {1'($urandom % 4 == 0), rm[3 + $urandom % 6], 2'($urandom)};
      case ($urandom % 3)
        0: addr[3:0] = 4'h1;
        1: addr[3:0] = 4'h6;
        default: addr[3:0] = addr[3:0];
      endcase
      chip_select_n = $urandom % 4 == 0;
      power_good = $urandom % 4 == 0;
      {epp_enable, ecp_mode, drive_sel} = 4'($urandom);
      {density_select, rate_bit_0, rate_bit_1} = 3'($urandom);
      @(negedge ref_clk);
      q.push_back('{"density and selects", exp_dec()});
      probe = 1'b1;
      @(negedge ref_clk);
      probe = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    stop_test();
  end
endmodule

/* File: icad_config_decode_props.sv */
`timescale 1ns/1ps
// Watches the config decode ports for register and select relations
module icad_config_decode_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cfg_mode,
  input wire logic index_wr,
  input wire logic data_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic [7:0] config_index_reg,
  input wire logic [10:0] addr,
  input wire logic chip_select_n,
  input wire logic power_good,
  input wire logic ecp_mode,
  input wire icad_pkg::icad_sel_t sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Read issued outside configuration mode
  sequence s_rd_off;
    data_rd && !cfg_mode;
  endsequence
  // Index load in configuration mode
  sequence s_idx_load;
    cfg_mode && index_wr;
  endsequence
  rd_outside_cfg_a: assert property (s_rd_off |=> host_rdata == 8'h00)
    else $error("read outside config mode gave nonzero data");
  index_load_a: assert property (s_idx_load |=>
    config_index_reg == $past(host_wdata)) else $error("index not loaded");
  index_hold_a: assert property (!(cfg_mode && index_wr) |=>
    $stable(config_index_reg)) else $error("index changed without load");
  rdata_hold_a: assert property (!data_rd |=> $stable(host_rdata))
    else $error("read data changed without a read");
  game_qual_a: assert property (sel.game_port_select |->
    $past(!chip_select_n && !addr[10] && !power_good))
    else $error("game select without qualification");
  floppy_qual_a: assert property (sel.floppy_controller_sel |->
    $past(!chip_select_n && !addr[10] && !addr[3]))
    else $error("floppy select without qualification");
  ctrl_qual_a: assert property (sel.disk_ctrl_sel |->
    $past(!chip_select_n && !addr[10] && !addr[3]))
    else $error("disk control select without qualification");
  alt_nibble_a: assert property (sel.disk_alt_sel |->
    $past(!chip_select_n && !addr[10] && addr[3:0] == 4'h6))
    else $error("alternate status select on wrong nibble");
  printer_qual_a: assert property (sel.printer_sel |->
    $past(!chip_select_n && (ecp_mode || !addr[10])))
    else $error("printer select without qualification");
endmodule

bind icad_config_decode icad_config_decode_props icad_config_decode_props_i (
  .ref_clk(ref_clk), .nrst(nrst), .cfg_mode(cfg_mode),
  .index_wr(index_wr), .data_rd(data_rd), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .config_index_reg(config_index_reg),
  .addr(addr), .chip_select_n(chip_select_n), .power_good(power_good),
  .ecp_mode(ecp_mode), .sel(sel));

/* File: icad_host_model.sv */
`timescale 1ns/1ps
// Host side of the configuration port: index cycle, then data cycle
module icad_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_rdata,
  output logic index_wr,
  output logic data_wr,
  output logic data_rd,
  output logic [7:0] host_wdata,
  output logic rd_done,
  output logic [7:0] rd_byte
);
  // Idle state at time zero
  initial begin
    index_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    host_wdata = 8'h00;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // Load index, then one write or read; strobes last one cycle
  task automatic access(input logic w, input logic [7:0] i,
                        input logic [7:0] d);
    @(negedge ref_clk);
    index_wr = 1'b1;
    host_wdata = i;
    @(negedge ref_clk);
    index_wr = 1'b0;
    data_wr = w;
    data_rd = !w;
    host_wdata = d;
    @(negedge ref_clk);
    data_wr = 1'b0;
    data_rd = 1'b0;
    // Released bus shows the inverse so stale data is not trusted
    host_wdata = ~d;
    if (!w) begin
      rd_byte = host_rdata;
      rd_done = 1'b1;
      @(negedge ref_clk);
      rd_done = 1'b0;
    end
  endtask
endmodule

/* File: icad_pkg.sv */
// Shared constants and carriers for the I/O configuration decode block
package icad_pkg;

  // Configuration indices of the register slice
  localparam logic [7:0] IDX_TEST_LOW = 8'h0f;
  localparam logic [7:0] IDX_TEST_MID = 8'h10;
  localparam logic [7:0] IDX_TEST_HIGH = 8'h11;
  localparam logic [7:0] IDX_RSVD_FIRST = 8'h12;
  localparam logic [7:0] IDX_RSVD_LAST = 8'h1d;
  localparam logic [7:0] IDX_GAME_BASE = 8'h1e;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'h1f;
  localparam logic [7:0] IDX_FLOPPY_BASE = 8'h20;
  localparam logic [7:0] IDX_DISK_CTRL = 8'h21;
  localparam logic [7:0] IDX_DISK_ALT = 8'h22;
  localparam logic [7:0] IDX_PRINTER = 8'h23;

  // Reset values
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_GAME_BASE = 8'h80;
  localparam logic [7:0] RST_DRIVE_TYPE = 8'h00;
  localparam logic [7:0] RST_FLOPPY_BASE = 8'h3c;
  localparam logic [7:0] RST_DISK_CTRL = 8'h3c;
  localparam logic [7:0] RST_DISK_ALT = 8'h3d;
  localparam logic [7:0] RST_PRINTER = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;

  // Writable bit masks; cleared bits keep their reset value
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_TEST_HIGH = 8'h03;
  localparam logic [7:0] WMASK_BASE6 = 8'hfc;

  // Game select mode field, bits 1:0
  localparam int GAME_MODE_LSB = 0;
  localparam logic [1:0] GAME_OFF = 2'h0;
  localparam logic [1:0] GAME_ONE_BYTE = 2'h1;
  localparam logic [1:0] GAME_EIGHT = 2'h2;
  localparam logic [1:0] GAME_SIXTEEN = 2'h3;

  // Low address nibble patterns
  localparam logic [3:0] NIB_GAME_ONE = 4'h1;
  localparam logic [3:0] NIB_ALT_STATUS = 4'h6;

  // Drive type codes, first bit in the upper position
  localparam logic [1:0] DT_DENSITY_SELECT = 2'h0;
  localparam logic [1:0] DT_RATES_10 = 2'h1;
  localparam logic [1:0] DT_DENSITY_SELECT_INV = 2'h2;
  localparam logic [1:0] DT_RATES_01 = 2'h3;

  // Stored configuration bytes
  typedef struct packed {
    logic [7:0] test_bits_low;
    logic [7:0] test_bits_mid;
    logic [7:0] test_bits_high;
    logic [7:0] game_select_base;
    logic [7:0] drive_type_select;
    logic [7:0] floppy_base;
    logic [7:0] disk_ctrl_block_base;
    logic [7:0] disk_alt_status_base;
    logic [7:0] printer_port_base;
  } icad_regs_t;

  // Decoded select outputs, active high
  typedef struct packed {
    logic game_port_select;
    logic floppy_controller_sel;
    logic disk_ctrl_sel;
    logic disk_alt_sel;
    logic printer_sel;
  } icad_sel_t;

endpackage
